/* File: design/acs_pkg.sv */
// Purpose: shared constants, types and timing tables of the sequencer
// Assumes: timing table counts are in master clock cycles, framing counts in serial clocks
// Notes: master clock is an enable pulse every MCLK_DIV system clocks
package acs_pkg;

  // ============================================================
  // command byte layout
  localparam int CMD_MSB = 7;        // set on every action command
  localparam int CMD_CONT_BIT = 6;   // continuous conversion select
  localparam logic [2:0] CC_CONV = 3'h0;    // plain conversion
  localparam logic [2:0] CC_OFFSET = 3'h5;  // offset calibration
  localparam logic [2:0] CC_GAIN = 3'h6;    // gain calibration
  localparam logic [7:0] STAY_CODE = 8'h00;  // keep converting
  localparam logic [7:0] EXIT_CODE = 8'hFF;  // leave continuous mode

  // ============================================================
  // serial framing
  localparam logic [5:0] CMD_BITS = 6'h08;   // bits per command byte
  localparam logic [5:0] FLAG_CLOCKS = 6'h08; // flag clearing clocks
  localparam logic [5:0] DATA_CLOCKS = 6'h20; // result word clocks

  // ============================================================
  // register layout and reset values
  localparam logic [31:0] GAIN_RESET = 32'h0100_0000; // unity gain
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
  localparam int RES_LSB = 8;   // result occupies [31:8]
  localparam int OVR_BIT = 2;   // over_range_flag position

  // ============================================================
  // timing
  localparam int CNT_W = 22;               // widest count in tables
  localparam logic [3:0] MCLK_DIV = 4'h8;  // 40 MHz to 5 MHz
  localparam logic [CNT_W-1:0] OFS_TRIM0 = 22'd608;
  localparam logic [CNT_W-1:0] OFS_TRIM1 = 22'd729;
  localparam logic [CNT_W-1:0] GAIN_TRIM0 = 22'd128;
  localparam logic [CNT_W-1:0] GAIN_TRIM1 = 22'd153;
  localparam logic [CNT_W-1:0] LATER_BASE0 = 22'd40960;
  localparam logic [CNT_W-1:0] LATER_BASE1 = 22'd49152;
  localparam logic [CNT_W-1:0] FAST_BASE0 = 22'd1280;
  localparam logic [CNT_W-1:0] FAST_BASE1 = 22'd1536;

  // sequencer states
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,     // shifting in a command byte
    ST_BUSY = 3'b001,    // converting or calibrating, line high
    ST_FLAG = 3'b010,    // result ready, line low
    ST_CLR = 3'b011,     // eight flag clearing clocks
    ST_DATA = 3'b100,    // shifting out the result word
    ST_CALDONE = 3'b101  // calibration finished, line low
  } acs_state_t;

  // action of the running command
  typedef enum logic [1:0] {
    K_CONV = 2'b00,
    K_OFFSET = 2'b01,
    K_GAIN = 2'b10
  } acs_kind_t;

  // single conversion length; unused codes fall back to 0000
  function automatic logic [CNT_W-1:0] acs_single(input logic f,
                                                   input logic [3:0] w);
    case ({f, w})
      5'h01: acs_single = 22'd335288;
      5'h02: acs_single = 22'd662968;
      5'h03: acs_single = 22'd1318328;
      5'h04: acs_single = 22'd2629048;
      5'h08: acs_single = 22'd7592;
      5'h09: acs_single = 22'd17848;
      5'h0A: acs_single = 22'd28088;
      5'h0B: acs_single = 22'd48568;
      5'h0C: acs_single = 22'd89528;
      5'h10: acs_single = 22'd205738;
      5'h11: acs_single = 22'd402346;
      5'h12: acs_single = 22'd795562;
      5'h13: acs_single = 22'd1581994;
      5'h14: acs_single = 22'd3154858;
      5'h18: acs_single = 22'd9110;
      5'h19: acs_single = 22'd21418;
      5'h1A: acs_single = 22'd33706;
      5'h1B: acs_single = 22'd58282;
      5'h1C: acs_single = 22'd107434;
      default: acs_single = f ? 22'd205738 : 22'd171448;
    endcase
  endfunction : acs_single

  // first continuous conversion length
  function automatic logic [CNT_W-1:0] acs_first(input logic f,
                                                  input logic [3:0] w);
    case ({f, w})
      5'h01: acs_first = 22'd171448;
      5'h02: acs_first = 22'd335288;
      5'h03: acs_first = 22'd662968;
      5'h04: acs_first = 22'd1318328;
      5'h08: acs_first = 22'd2472;
      5'h09: acs_first = 22'd12728;
      5'h0A: acs_first = 22'd17848;
      5'h0B: acs_first = 22'd28088;
      5'h0C: acs_first = 22'd48568;
      5'h10: acs_first = 22'd107434;
      5'h11: acs_first = 22'd205738;
      5'h12: acs_first = 22'd402346;
      5'h13: acs_first = 22'd795562;
      5'h14: acs_first = 22'd1581994;
      5'h18: acs_first = 22'd2966;
      5'h19: acs_first = 22'd15274;
      5'h1A: acs_first = 22'd21418;
      5'h1B: acs_first = 22'd33706;
      5'h1C: acs_first = 22'd58282;
      default: acs_first = f ? 22'd107434 : 22'd89528;
    endcase
  endfunction : acs_first

  // later continuous conversions double with each code step
  function automatic logic [CNT_W-1:0] acs_later(input logic f,
                                                  input logic [3:0] w);
    logic [CNT_W-1:0] b;
    b = w[3] ? (f ? FAST_BASE1 : FAST_BASE0)
             : (f ? LATER_BASE1 : LATER_BASE0);
    // unused codes fall back to code 0000 and so cannot overflow
    if (w[2:0] > 3'h4) acs_later = f ? LATER_BASE1 : LATER_BASE0;
    else acs_later = b << w[2:0];
  endfunction : acs_later

endpackage : acs_pkg

/* File: design/acs_pinsync.sv */
// Purpose: brings the serial clock and data pins into the CLK domain
// Assumes: pins toggle far slower than CLK
// Notes: edges are found on the second stage only
`timescale 1ns/1ps
module acs_pinsync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  output logic sclk_rise,
  output logic sclk_fall,
  output logic sdi_s
);
  // ============================================================
  // two-flop synchronisers plus one history stage
  logic sclk_m_q;  // metastable stage, read by sclk_s_q only
  logic sclk_s_q;  // synchronised level
  logic sclk_h_q;  // previous synchronised level
  logic sdi_m_q;   // metastable stage, read by sdi_s_q only
  logic sdi_s_q;   // synchronised level

  // sampling chain
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_h_q <= 1'b0;
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end else begin
      sclk_m_q <= sclk_pin;
      sclk_s_q <= sclk_m_q;
      sclk_h_q <= sclk_s_q;
      sdi_m_q <= sdi_pin;
      sdi_s_q <= sdi_m_q;
    end
  end

  // edge decode on settled stages
  assign sclk_rise = sclk_s_q & ~sclk_h_q;
  assign sclk_fall = ~sclk_s_q & sclk_h_q;
  assign sdi_s = sdi_s_q;
endmodule : acs_pinsync

/* File: design/acs_mtimer.sv */
// Purpose: master clock divider and conversion length down counter
// Assumes: load is at least one
// Notes: done pulses for one CLK cycle when the count expires
`timescale 1ns/1ps
module acs_mtimer
  import acs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic stop,
  input wire logic [CNT_W-1:0] load,
  output logic busy,
  output logic done
);
  // ============================================================
  // master clock enable
  logic [3:0] div_q;         // divider phase
  logic mtick;               // one master clock cycle
  logic [CNT_W-1:0] cnt_q;   // remaining master cycles
  logic busy_q;              // counting

  assign mtick = (div_q == MCLK_DIV - 4'h1);

  // divider runs freely
  always_ff @(posedge clk) begin
    if (!nrst) div_q <= 4'h0;
    else div_q <= mtick ? 4'h0 : div_q + 4'h1;
  end

  // ============================================================
  // down counter; start wins over stop and expiry
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      busy_q <= 1'b1;
    end else if (stop) begin
      busy_q <= 1'b0;
    end else if (busy_q && mtick) begin
      cnt_q <= cnt_q - 22'd1;
      if (cnt_q == 22'd1) busy_q <= 1'b0;
    end
  end

  // done ignores start: the sequencer restarts on done, a loop otherwise
  assign done = busy_q && mtick && (cnt_q == 22'd1) && !stop;
  assign busy = busy_q;

  // counter takes the requested length
  a_timer_load : assert property (@(posedge clk) disable iff (!nrst)
    start |=> busy_q && cnt_q == $past(load))
    else $error("timer did not load its length");
endmodule : acs_mtimer

/* File: design/acs_seq.sv */
// Purpose: command driven calibration and conversion sequencer
// Assumes: filter result and calibration word are valid at timer end
// Notes: serial pins are sampled through two flops before use
`timescale 1ns/1ps

module acs_seq
  import acs_pkg::*;
#(
  parameter int TIME_SHIFT = 0  // divides every length for simulation
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SCLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic FILTER_RATE_SELECT,
  input wire logic [3:0] WORD_RATE_FIELD,
  input wire logic UNIPOLAR,
  input wire logic [23:0] CONV_WORD,
  input wire logic OVER_RANGE_IN,
  input wire logic [31:0] CAL_WORD,
  output logic SERIAL_DATA_OUT,
  output logic [31:0] GAIN_REG,
  output logic [31:0] OFFSET_REG,
  output logic [31:0] CONV_DATA,
  output logic DATA_MODE,
  output logic CONT_MODE,
  output logic [3:0] RUN_WORD_RATE,
  output logic RUN_FILTER_RATE_SELECT,
  output logic RUN_UNIPOLAR,
  output logic [1:0] RUN_KIND
);
  // ============================================================
  // declarations
  acs_state_t state_q, state_d;  // sequencer state
  acs_kind_t kind_q;             // action being run
  logic [5:0] cnt_q;             // serial clocks in this phase
  logic [7:0] sr_q;              // command or control byte
  logic [31:0] sh_q;             // outgoing word
  logic [31:0] data_q;           // conversion data register
  logic [31:0] gain_q;           // gain register
  logic [31:0] offset_q;         // offset register
  logic sdo_q;                   // serial_data_out level
  logic cont_q;                  // continuous mode active
  logic exit_q;                  // leave after this read
  logic [3:0] wr_q;              // latched word_rate_field
  logic frs_q;                   // latched filter_rate_select
  logic uni_q;                   // latched polarity
  logic dmode_q;                 // port in data mode
  logic rise, fall, sdi_s;       // synchronised pin events
  logic tmr_busy, tmr_done;      // timer handshake
  logic tmr_start, tmr_stop;     // timer control
  logic [CNT_W-1:0] tmr_load;    // timer length

  // scale a master clock count, never below one cycle
  function automatic logic [CNT_W-1:0] scaled(input logic [CNT_W-1:0] c);
    logic [CNT_W-1:0] s;
    s = c >> TIME_SHIFT;
    scaled = (s == '0) ? 22'd1 : s;
  endfunction : scaled

  // ============================================================
  // pin synchroniser and timer
  acs_pinsync u_sync (
    .clk(CLK),
    .nrst(NRST),
    .sclk_pin(SCLK),
    .sdi_pin(SERIAL_DATA_IN),
    .sclk_rise(rise),
    .sclk_fall(fall),
    .sdi_s(sdi_s)
  );

  acs_mtimer u_tmr (
    .clk(CLK),
    .nrst(NRST),
    .start(tmr_start),
    .stop(tmr_stop),
    .load(tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ============================================================
  // command decode
  wire [7:0] cmd_byte = {sr_q[6:0], sdi_s};       // byte being completed
  wire byte_end = rise && (cnt_q == CMD_BITS - 6'h01);
  wire cmd_take = (state_q == ST_CMD) && byte_end && cmd_byte[CMD_MSB];
  wire cmd_cont = cmd_byte[CMD_CONT_BIT];
  wire cmd_ofs = (cmd_byte[2:0] == CC_OFFSET);
  wire cmd_gain = (cmd_byte[2:0] == CC_GAIN);
  wire clr_end = (state_q == ST_CLR) && rise &&
                 (cnt_q == FLAG_CLOCKS - 6'h01);
  wire data_end = (state_q == ST_DATA) && rise &&
                  (cnt_q == DATA_CLOCKS - 6'h01);
  wire waiting = (state_q == ST_BUSY) || (state_q == ST_FLAG);
  // fresh word: result in [31:8], over_range_flag at bit 2
  wire [31:0] fresh = {CONV_WORD, 5'h00, OVER_RANGE_IN, 2'h0};

  // lengths follow the settings present when the command lands
  // offset trim
  wire [CNT_W-1:0] ofs_len = acs_single(FILTER_RATE_SELECT,
    WORD_RATE_FIELD) - (FILTER_RATE_SELECT ? OFS_TRIM1 : OFS_TRIM0);
  wire [CNT_W-1:0] gain_len = acs_single(FILTER_RATE_SELECT,
    WORD_RATE_FIELD) - (FILTER_RATE_SELECT ? GAIN_TRIM1 : GAIN_TRIM0);
  wire [CNT_W-1:0] one_len = acs_single(FILTER_RATE_SELECT,
    WORD_RATE_FIELD);
  wire [CNT_W-1:0] first_len = acs_first(FILTER_RATE_SELECT,
    WORD_RATE_FIELD);
  wire [CNT_W-1:0] later_len = acs_later(frs_q, wr_q);

  // continuous restart
  // timer restarts by itself while continuous mode lasts
  assign tmr_start = (cmd_take && (cmd_ofs || cmd_gain || cmd_cont ||
                      cmd_byte[2:0] == CC_CONV)) ||
                     (tmr_done && cont_q && !exit_q);
  assign tmr_stop = data_end && (!cont_q || exit_q);
  assign tmr_load = !cmd_take ? scaled(later_len) :
                    cmd_ofs ? scaled(ofs_len) :
                    cmd_gain ? scaled(gain_len) :
                    cmd_cont ? scaled(first_len) : scaled(one_len);

  // ============================================================
  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_CMD: begin
        if (tmr_start) state_d = ST_BUSY;
      end
      ST_BUSY: begin
        if (tmr_done && kind_q != K_CONV) state_d = ST_CALDONE;
        else if (tmr_done) state_d = ST_FLAG;
      end
      ST_FLAG: begin
        if (rise) state_d = ST_CLR;
      end
      ST_CLR: begin
        if (clr_end) state_d = ST_DATA;
      end
      ST_DATA: begin
        if (data_end) state_d = (cont_q && !exit_q) ? ST_BUSY : ST_CMD;
      end
      ST_CALDONE: begin
        // line stays low until the next byte starts
        if (rise) state_d = ST_CMD;
      end
      default: state_d = ST_CMD;
    endcase
  end

  // ============================================================
  // state and serial counters
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_q <= ST_CMD;
      dmode_q <= 1'b0;
      cnt_q <= 6'h00;
      sr_q <= 8'h00;
    end else begin
      state_q <= state_d;
      dmode_q <= (state_d != ST_CMD);
      // only the rise leaving a calibration flag is a command bit
      if (state_q != state_d) cnt_q <= (state_q == ST_CALDONE ||
        state_d == ST_CLR) ? 6'h01 : 6'h00;
      else if (rise) cnt_q <= byte_end && state_q == ST_CMD ? 6'h00
                              : cnt_q + 6'h01;
      if (rise) sr_q <= cmd_byte;
    end
  end

  // ============================================================
  // latched command and settings
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      kind_q <= K_CONV;
      cont_q <= 1'b0;
      exit_q <= 1'b0;
      wr_q <= 4'h0;
      frs_q <= 1'b0;
      uni_q <= 1'b0;
    end else if (cmd_take) begin
      kind_q <= cmd_ofs ? K_OFFSET : (cmd_gain ? K_GAIN : K_CONV);
      cont_q <= cmd_cont && !cmd_ofs && !cmd_gain;
      exit_q <= 1'b0;
      wr_q <= WORD_RATE_FIELD;
      frs_q <= FILTER_RATE_SELECT;
      uni_q <= UNIPOLAR;
    end else begin
      if (clr_end && cont_q) exit_q <= (cmd_byte == EXIT_CODE);
      if (clr_end && cmd_byte == STAY_CODE) exit_q <= 1'b0;
      if (tmr_stop) cont_q <= 1'b0;
    end
  end

  // ============================================================
  // calibration and data registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      gain_q <= GAIN_RESET;
      offset_q <= OFFSET_RESET;
      data_q <= '0;
    end else if (tmr_done && waiting) begin
      if (kind_q == K_OFFSET) offset_q <= CAL_WORD;
      if (kind_q == K_GAIN) gain_q <= CAL_WORD;
      if (kind_q == K_CONV) data_q <= fresh;
    end
  end

  // ============================================================
  // serial_data_out drive
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sdo_q <= 1'b1;
      sh_q <= '0;
    end else begin
      case (state_d)
        ST_CMD, ST_BUSY: sdo_q <= 1'b1;
        ST_FLAG, ST_CALDONE, ST_CLR: sdo_q <= 1'b0;
        ST_DATA: begin
          if (fall) sdo_q <= sh_q[31];
        end
        default: sdo_q <= 1'b1;
      endcase
      if (clr_end) sh_q <= data_q;
      else if (fall && state_q == ST_DATA) sh_q <= {sh_q[30:0], 1'b0};
    end
  end

  // outputs straight from flops
  assign SERIAL_DATA_OUT = sdo_q;
  assign GAIN_REG = gain_q;
  assign OFFSET_REG = offset_q;
  assign CONV_DATA = data_q;
  assign CONT_MODE = cont_q;
  assign RUN_WORD_RATE = wr_q;
  assign RUN_FILTER_RATE_SELECT = frs_q;
  assign RUN_UNIPOLAR = uni_q;
  assign RUN_KIND = kind_q;
  assign DATA_MODE = dmode_q;

  // ============================================================
  // checks
  sequence s_clr_end;
    state_q == ST_CLR && rise && cnt_q == 6'h07;
  endsequence

  sequence s_read_end;
    state_q == ST_DATA && rise && cnt_q == 6'h1F;
  endsequence

  a_gain_unity : assert property (@(posedge CLK)
    !NRST |=> gain_q == 32'h0100_0000 && offset_q == 32'h0)
    else $error("registers not at reset values");

  a_cal_low : assert property (@(posedge CLK) disable iff (!NRST)
    state_q == ST_CALDONE && !rise |=> !sdo_q)
    else $error("line rose before next command");

  a_wait_high : assert property (@(posedge CLK) disable iff (!NRST)
    state_q == ST_BUSY && $past(state_q) == ST_BUSY |-> sdo_q)
    else $error("line low while waiting");

  a_flag_fall : assert property (@(posedge CLK) disable iff (!NRST)
    state_q == ST_BUSY && tmr_done && kind_q == K_CONV
    |=> state_q == ST_FLAG ##1 !sdo_q)
    else $error("result not flagged");

  a_ofs_store : assert property (@(posedge CLK) disable iff (!NRST)
    state_q == ST_BUSY && tmr_done && kind_q == K_OFFSET
    |=> offset_q == $past(CAL_WORD) && gain_q == $past(gain_q))
    else $error("offset result not stored");

  a_clr_eight : assert property (@(posedge CLK) disable iff (!NRST)
    s_clr_end |=> state_q == ST_DATA && sh_q == data_q)
    else $error("data phase did not follow flag clear");

  a_single_exit : assert property (@(posedge CLK) disable iff (!NRST)
    s_read_end and !cont_q |=> state_q == ST_CMD && !tmr_busy)
    else $error("single read did not end data mode");

  a_cont_exit : assert property (@(posedge CLK) disable iff (!NRST)
    s_read_end and exit_q |=> state_q == ST_CMD ##1 !cont_q)
    else $error("continuous mode not left");

  a_cont_rerun : assert property (@(posedge CLK) disable iff (!NRST)
    tmr_done && cont_q && !exit_q |=> tmr_busy)
    else $error("continuous conversion did not restart");

  a_ofs_len : assert property (@(posedge CLK) disable iff (!NRST)
    cmd_take && cmd_ofs |-> one_len - ofs_len ==
      (FILTER_RATE_SELECT ? 22'd729 : 22'd608))
    else $error("offset calibration length wrong");
endmodule : acs_seq

/* File: tb/acs_host.sv */
// Purpose: host side of the three-wire port
// Assumes: 200 ns shift clock that stands low between frames
// Notes: data out is sampled just before each rising edge
`timescale 1ns/1ps
module acs_host (
  output logic SCLK,
  output logic SERIAL_DATA_IN,
  input wire logic SERIAL_DATA_OUT
);
  // ============================================================
  // idle levels, clock stands still outside frames
  initial begin
    SCLK = 1'b0;
    SERIAL_DATA_IN = 1'b0;
  end

  // one shift clock; long low phase lets data out settle
  task automatic clk_bit(input logic b, output logic s);
    SERIAL_DATA_IN = b;
    #150;
    s = SERIAL_DATA_OUT;
    SCLK = 1'b1;
    #50;
    SCLK = 1'b0;
  endtask : clk_bit

  task automatic send_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
  endtask : send_byte

  // eight flag clocks, then 32 data clocks
  task automatic read_word(input logic [7:0] b, output logic [31:0] w);
    send_byte(b);
    for (int i = 31; i >= 0; i--) begin
      clk_bit(1'b0, w[i]);
    end
  endtask : read_word
endmodule : acs_host

/* File: tb/acs_seq_test.sv */
// Purpose: self-checking bench of the sequencer
// Assumes: TIME_SHIFT 8 shortens every conversion length
// Notes: the host waits for each flag, slow rate, small gain
`timescale 1ns/1ps
module acs_seq_test
  import acs_pkg::*;
;
  // ============================================================
  // stimulus and observed signals
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic filter_rate_select = 1'b0;
  logic [3:0] wr = 4'h0;
  logic unip = 1'b1;
  logic [23:0] conv_w = 24'hA5C3E1;
  logic ovr = 1'b1;
  logic [31:0] cal_w = 32'h0000_0000;
  logic sclk, serial_data_in, serial_data_out, dmode, cmode, run_frs, run_unip;
  logic [31:0] gain, offs, cdata, w, eg, eo;
  logic [3:0] run_wr;
  logic [1:0] run_kind;
  logic [7:0] r_cmd [3] = '{8'h85, 8'h86, 8'h85};
  logic [31:0] r_cal [3] = '{32'h0012_3400, 32'h0150_0000, 32'hFFFE_0000};
  int n_fail = 0;
  int compares = 0;
  int t_cal, t_ofs, t_single, t1, t2;

  always #12.5 CLK = ~CLK;

  acs_seq #(.TIME_SHIFT(8)) acs_seq_inst (.CLK(CLK), .NRST(NRST),
    .SCLK(sclk), .SERIAL_DATA_IN(serial_data_in), .FILTER_RATE_SELECT(filter_rate_select),
    .WORD_RATE_FIELD(wr), .UNIPOLAR(unip), .CONV_WORD(conv_w),
    .OVER_RANGE_IN(ovr), .CAL_WORD(cal_w), .SERIAL_DATA_OUT(serial_data_out),
    .GAIN_REG(gain), .OFFSET_REG(offs), .CONV_DATA(cdata),
    .DATA_MODE(dmode), .CONT_MODE(cmode), .RUN_WORD_RATE(run_wr),
    .RUN_FILTER_RATE_SELECT(run_frs), .RUN_UNIPOLAR(run_unip),
    .RUN_KIND(run_kind));

  acs_host acs_host_inst (.SCLK(sclk), .SERIAL_DATA_IN(serial_data_in),
    .SERIAL_DATA_OUT(serial_data_out));

  // ============================================================
  // compare, flag wait and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string m);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  // bounded wait for the flag; count is in CLK cycles
  task automatic wait_flag(output int n);
    n = 0;
    while (serial_data_out !== 1'b0 && n < 20000) begin
      @(negedge CLK);
      n++;
    end
    chk(32'(n < 20000), 32'h1, "flag timeout");
    @(negedge CLK);
  endtask : wait_flag

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // ============================================================
  // main sequence
  initial begin
    repeat (10) @(negedge CLK);
    NRST = 1'b1;
    chk(gain, GAIN_RESET, "gain reset");
    chk(offs, OFFSET_RESET, "offset reset");
    chk(32'(serial_data_out), 32'h1, "line idle");
    $display("test reset done");
    eg = GAIN_RESET;
    eo = OFFSET_RESET;
    repeat (4) @(negedge CLK);
    // rows: calibrations, the last overwrites the first
    for (int i = 0; i < 3; i++) begin
      cal_w = r_cal[i];
      acs_host_inst.send_byte(r_cmd[i]);
      wait_flag(t_cal);
      if (i == 0)
        t_ofs = t_cal;
      if (r_cmd[i][2:0] == CC_GAIN)
        eg = r_cal[i];
      else
        eo = r_cal[i];
      repeat (40) @(negedge CLK);
      chk(32'(serial_data_out), 32'h0, "cal flag held");
      chk(32'(run_kind), (r_cmd[i][2:0] == CC_GAIN) ? 32'(K_GAIN) :
          32'(K_OFFSET), "cal kind");
      chk(32'(run_unip), 32'h1, "cal polarity");
      chk(gain, eg, "gain reg");
      chk(offs, eo, "offset reg");
      $display("test calibration row %0d done", i);
    end
    // single conversion straight after a calibration flag
    acs_host_inst.send_byte(8'h80);
    repeat (4) @(negedge CLK);
    chk(32'(dmode), 32'h1, "data mode");
    chk(32'(serial_data_out), 32'h1, "line waiting");
    wait_flag(t_single);
    chk(32'(t_ofs < t_single), 32'h1, "offset cal shorter");
    // 171448 >> 8 master cycles of 8 CLK each
    chk(32'(t_single > 5300 && t_single < 5400), 32'h1, "single len");
    chk(cdata, {conv_w, 8'h00} | (32'(ovr) << OVR_BIT), "data reg");
    chk(32'(run_kind), 32'(K_CONV), "conv kind");
    acs_host_inst.read_word(STAY_CODE, w);
    chk(w, {conv_w, 8'h00} | (32'(ovr) << OVR_BIT), "word");
    repeat (8) @(negedge CLK);
    chk(32'(dmode), 32'h0, "command mode");
    chk(32'(serial_data_out), 32'h1, "line idle");
    $display("test single done");
    // continuous: stay code, then exit code
    unip = 1'b0;
    acs_host_inst.send_byte(8'hC0);
    wait_flag(t1);
    chk(32'(cmode), 32'h1, "cont mode");
    chk(32'(run_unip), 32'h0, "cont polarity");
    acs_host_inst.read_word(STAY_CODE, w);
    chk(w, {conv_w, 8'h00} | (32'(ovr) << OVR_BIT), "first word");
    conv_w = 24'h3C5A96;
    ovr = 1'b0;
    repeat (8) @(negedge CLK);
    chk(32'(cmode), 32'h1, "still cont");
    wait_flag(t2);
    chk(32'(t2 < t1), 32'h1, "later shorter");
    acs_host_inst.read_word(EXIT_CODE, w);
    chk(w, {conv_w, 8'h00}, "new word");
    repeat (8) @(negedge CLK);
    chk(32'(cmode | dmode), 32'h0, "exit");
    $display("test continuous done");
    // fast word rate with the second filter rate: 9110 >> 8 cycles
    filter_rate_select = 1'b1;
    wr = 4'h8;
    acs_host_inst.send_byte(8'h80);
    wait_flag(t1);
    chk(32'(t1 > 260 && t1 < 300), 32'h1, "fast single len");
    chk(32'(run_frs), 32'h1, "run filter rate");
    chk(32'(run_wr), 32'h8, "run word rate");
    acs_host_inst.read_word(STAY_CODE, w);
    chk(w, {conv_w, 8'h00} | (32'(ovr) << OVR_BIT), "fast word");
    $display("test fast single done");
    // reset in mid-run brings every register back
    repeat (4) @(negedge CLK);
    NRST = 1'b0;
    repeat (3) @(negedge CLK);
    NRST = 1'b1;
    chk(gain, GAIN_RESET, "gain rereset");
    chk(offs, OFFSET_RESET, "offset rereset");
    chk(cdata, 32'h0, "data rereset");
    chk(32'(dmode | cmode), 32'h0, "modes rereset");
    chk(32'(serial_data_out), 32'h1, "line rereset");
    $display("test mid reset done");
    repeat (4) @(negedge CLK);
    // byte without MSB is refused
    acs_host_inst.send_byte(8'h05);
    repeat (8) @(negedge CLK);
    chk(32'(dmode), 32'h0, "refused byte");
    $display("test refused done");
    end_of_test();
  end

  // watchdog, a little over twice the expected run
  initial begin
    #1500000;
    n_fail++;
    end_of_test();
  end
endmodule : acs_seq_test
